// ===== design/rtc_hour_consts.svh
// Offsets, field positions, reset values and timing counts of the hour/weekday block.
// Assumes an 8-bit register port with word-free byte offsets.
`ifndef RTC_HOUR_CONSTS_SVH
`define RTC_HOUR_CONSTS_SVH
`define OFS_HOUR_COUNT 16'hf06a
`define OFS_WEEKDAY_COUNT 16'hf06b
`define OFS_CLOCK_CONTROL_ONE 16'hf06c
`define OFS_CLOCK_SOURCE_SELECT 16'hf06f
`define OFS_MINUTE_COUNT 16'hf069
`define OFS_SECOND_COUNT 16'hf068
`define BIT_BUSY 7
`define BIT_RUN 7
`define BIT_FORMAT 6
`define BIT_AFTERNOON 5
`define BIT_SOFT_RESET 4
`define BIT_SRC_RTC 3
`define RST_CLOCK_SOURCE_SELECT 8'h08
`define WEEKDAY_SATURDAY 3'h6
`define BUSY_CYCLES 4'h3
`endif

// ===== design/rtc_hour_pkg.sv
// Types shared by the hour/weekday block.
// Assumes the constants header sits beside it.
package rtc_hour_pkg;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_busy = 2'b01
  } upd_state_t;
endpackage

// ===== design/rtc_hour_weekday.sv
// Hour, weekday and control part of a calendar clock with its own seconds/minutes chain.
// Assumes a 32.768 kHz tick pulse synchronous to clk_sys and a plain register port.
//
// Contract
// (R01) Busy bit 7 high while counters update
// (R02) Software uses values only when busy low
// (R03) Hour bit 6 reads zero, ignores writes
// (R04) Hour tens digit in bits 5:4
// (R05) Hour ones digit 0-9, carries into tens
// (R06) Weekday binary 0-6, code 7 invalid
// (R07) Reserved weekday and control bits read zero
// (R08) Run bit 7 stops or starts counting
// (R09) Format bit 6 selects 12 or 24 hours
// (R10) Afternoon bit 5 marks half of day
// (R11) Soft reset holds all but source select
// (R12) Software clears soft reset after setting it
// (R13) Counters tick from 32.768 kHz when selected
// (R14) Minutes 00-59 supply the hourly carry
// (R15) Hour wrap advances weekday, toggles afternoon; code holds weekday at noon and afternoon in 24-hour mode
`timescale 1ns/1ps
`include "rtc_hour_consts.svh"
module rtc_hour_weekday #(
  parameter int TICKS_PER_SECOND = 32768
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  // Time base
  input wire logic tick_32k,
  // Register port
  input wire rtc_hour_pkg::bus_req_t bus,
  output logic [7:0] rdata
);
  import rtc_hour_pkg::*;

  ////////////////////////////////////////////////////////////////
  logic [14:0] prescale, next_prescale;
  logic [3:0] sec_ones, next_sec_ones, min_ones, next_min_ones, hr_ones, next_hr_ones;
  logic [2:0] sec_tens, next_sec_tens, min_tens, next_min_tens;
  logic [1:0] hr_tens, next_hr_tens;
  logic [2:0] weekday, next_weekday;
  logic run, next_run, fmt24, next_fmt24, afternoon, next_afternoon;
  logic soft_rst, next_soft_rst;
  logic [7:0] src_sel, next_src_sel;
  upd_state_t upd_state, next_upd_state;
  logic [3:0] busy_cnt, next_busy_cnt;
  logic [7:0] next_rdata;
  logic busy, sec_tick;
  logic [4:0] hour_bin;
  logic hour_carry;

  assign busy = (upd_state == st_busy); // R01
  // Only the RTC source setting counts time
  assign sec_tick = run && src_sel[`BIT_SRC_RTC] && tick_32k && !soft_rst
    && (prescale == 15'(TICKS_PER_SECOND - 1)); // R08 R13
  assign hour_bin = 5'(hr_tens) * 5'd10 + 5'(hr_ones); // R04
  // Last tick of the hour, the one that reaches the hour digits
  assign hour_carry = sec_tick && sec_ones == 4'h9 && sec_tens == 3'h5
    && min_ones == 4'h9 && min_tens == 3'h5; // R14

  ////////////////////////////////////////////////////////////////
  // Counting and register writes
  always_comb begin
    next_prescale = prescale;
    next_sec_ones = sec_ones;
    next_sec_tens = sec_tens;
    next_min_ones = min_ones;
    next_min_tens = min_tens;
    next_hr_ones = hr_ones;
    next_hr_tens = hr_tens;
    next_weekday = weekday;
    next_run = run;
    next_fmt24 = fmt24;
    next_afternoon = afternoon;
    next_soft_rst = soft_rst;
    next_src_sel = src_sel;
    next_upd_state = upd_state;
    next_busy_cnt = busy_cnt;
    if (run && src_sel[`BIT_SRC_RTC] && tick_32k) begin // R13
      next_prescale = sec_tick ? 15'h0000 : prescale + 15'h0001;
    end
    if (sec_tick) begin
      next_upd_state = st_busy; // R01
      next_busy_cnt = `BUSY_CYCLES;
      if (sec_ones != 4'h9) begin
        next_sec_ones = sec_ones + 4'h1;
      end else begin
        next_sec_ones = 4'h0;
        if (sec_tens != 3'h5) begin
          next_sec_tens = sec_tens + 3'h1;
        end else begin
          next_sec_tens = 3'h0;
          if (min_ones != 4'h9) begin // R14
            next_min_ones = min_ones + 4'h1;
          end else begin
            next_min_ones = 4'h0;
            if (min_tens != 3'h5) begin
              next_min_tens = min_tens + 3'h1;
            end else begin
              next_min_tens = 3'h0;
              // Hourly carry
              if (hour_bin == (fmt24 ? 5'd23 : 5'd11)) begin // R09
                next_hr_ones = 4'h0;
                next_hr_tens = 2'h0;
                if (!fmt24) begin
                  next_afternoon = !afternoon; // R10 R15
                end
                if (fmt24 || afternoon) begin
                  // Invalid day code recovers to Sunday
                  next_weekday = (weekday >= `WEEKDAY_SATURDAY) ? 3'h0 : weekday + 3'h1; // R06 R15
                end
              end else if (hr_ones == 4'h9) begin
                next_hr_ones = 4'h0; // R05
                next_hr_tens = hr_tens + 2'h1;
              end else begin
                next_hr_ones = hr_ones + 4'h1; // R05
              end
            end
          end
        end
      end
    end else begin
      case (upd_state)
        st_busy: begin
          // Busy spans the whole cascade settle time
          if (busy_cnt == 4'h1) begin
            next_upd_state = st_idle;
          end
          next_busy_cnt = busy_cnt - 4'h1;
        end
        default: begin
        end
      endcase
    end
    if (bus.wr) begin
      case (bus.addr)
        `OFS_SECOND_COUNT: begin
          next_sec_tens = bus.wdata[6:4];
          next_sec_ones = bus.wdata[3:0];
        end
        `OFS_MINUTE_COUNT: begin
          next_min_tens = bus.wdata[6:4];
          next_min_ones = bus.wdata[3:0];
        end
        `OFS_HOUR_COUNT: begin
          next_hr_tens = bus.wdata[5:4]; // R03 R04
          next_hr_ones = bus.wdata[3:0];
        end
        `OFS_WEEKDAY_COUNT: begin
          next_weekday = bus.wdata[2:0]; // R06
        end
        `OFS_CLOCK_CONTROL_ONE: begin
          next_run = bus.wdata[`BIT_RUN]; // R08
          next_fmt24 = bus.wdata[`BIT_FORMAT]; // R09
          next_afternoon = bus.wdata[`BIT_AFTERNOON]; // R10
          next_soft_rst = bus.wdata[`BIT_SOFT_RESET]; // R11 R12
        end
        `OFS_CLOCK_SOURCE_SELECT: begin
          next_src_sel = {1'b0, bus.wdata[6:0]};
        end
        default: begin
        end
      endcase
    end
    // Soft reset clears everything but the source select and itself
    if (soft_rst) begin // R11
      next_prescale = 15'h0000;
      next_sec_ones = 4'h0;
      next_sec_tens = 3'h0;
      next_min_ones = 4'h0;
      next_min_tens = 3'h0;
      next_hr_ones = 4'h0;
      next_hr_tens = 2'h0;
      next_weekday = 3'h0;
      next_run = 1'b0;
      next_fmt24 = 1'b0;
      next_afternoon = 1'b0;
      next_upd_state = st_idle;
      next_busy_cnt = 4'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prescale <= 15'h0000;
      sec_ones <= 4'h0;
      sec_tens <= 3'h0;
      min_ones <= 4'h0;
      min_tens <= 3'h0;
      hr_ones <= 4'h0;
      hr_tens <= 2'h0;
      weekday <= 3'h0;
      run <= 1'b0;
      fmt24 <= 1'b0;
      afternoon <= 1'b0;
      soft_rst <= 1'b0;
      src_sel <= `RST_CLOCK_SOURCE_SELECT;
      upd_state <= st_idle;
      busy_cnt <= 4'h0;
    end else if (clk_en) begin
      prescale <= next_prescale;
      sec_ones <= next_sec_ones;
      sec_tens <= next_sec_tens;
      min_ones <= next_min_ones;
      min_tens <= next_min_tens;
      hr_ones <= next_hr_ones;
      hr_tens <= next_hr_tens;
      weekday <= next_weekday;
      run <= next_run;
      fmt24 <= next_fmt24;
      afternoon <= next_afternoon;
      soft_rst <= next_soft_rst;
      src_sel <= next_src_sel;
      upd_state <= next_upd_state;
      busy_cnt <= next_busy_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read path, data one cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        `OFS_SECOND_COUNT: next_rdata = {busy, sec_tens, sec_ones};
        `OFS_MINUTE_COUNT: next_rdata = {busy, min_tens, min_ones};
        `OFS_HOUR_COUNT: next_rdata = {busy, 1'b0, hr_tens, hr_ones}; // R01 R03
        `OFS_WEEKDAY_COUNT: next_rdata = {busy, 4'h0, weekday}; // R07
        `OFS_CLOCK_CONTROL_ONE: next_rdata = {run, fmt24, afternoon, soft_rst, 4'h0}; // R07
        `OFS_CLOCK_SOURCE_SELECT: next_rdata = src_sel;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (clk_en) begin
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  a_busy_on_tick: assert property (@(posedge clk_sys) disable iff (!nrst) // R01
    (clk_en && sec_tick && !bus.wr) |=> busy)
    else $error("busy not raised after a second tick");
  a_busy_clears: assert property (@(posedge clk_sys) disable iff (!nrst) // R01
    (clk_en && !busy) |=> (!busy || $past(sec_tick)))
    else $error("busy raised without a tick");
  a_hour_rsvd: assert property (@(posedge clk_sys) disable iff (!nrst) // R03
    $past(bus.rd && clk_en && bus.addr == `OFS_HOUR_COUNT) |-> (rdata[6] == 1'b0))
    else $error("hour reserved bit read as one");
  a_ones_wrap: assert property (@(posedge clk_sys) disable iff (!nrst) // R05
    (clk_en && hour_carry && !bus.wr && hr_ones == 4'h9 && hour_bin != (fmt24 ? 5'd23 : 5'd11))
    |=> (hr_ones == 4'h0 && hr_tens == $past(hr_tens) + 2'h1))
    else $error("hour ones digit did not carry into tens");
  a_day_valid: assert property (@(posedge clk_sys) disable iff (!nrst) // R06
    (clk_en && sec_tick && !bus.wr && weekday == `WEEKDAY_SATURDAY && min_tens == 3'h5
     && min_ones == 4'h9 && sec_tens == 3'h5 && sec_ones == 4'h9 && fmt24
     && hour_bin == 5'd23) |=> (weekday == 3'h0))
    else $error("weekday did not wrap to sunday");
  a_wk_rsvd: assert property (@(posedge clk_sys) disable iff (!nrst) // R07
    $past(bus.rd && clk_en && bus.addr == `OFS_WEEKDAY_COUNT) |-> (rdata[6:3] == 4'h0))
    else $error("weekday reserved bits set");
  a_stopped: assert property (@(posedge clk_sys) disable iff (!nrst) // R08
    (clk_en && !run && !bus.wr && !soft_rst)
    |=> ($stable(prescale) && $stable(sec_ones) && $stable(hr_ones) && $stable(weekday)))
    else $error("time advanced while stopped");
  a_hour_range: assert property (@(posedge clk_sys) disable iff (!nrst) // R09
    (clk_en && sec_tick && !bus.wr && !fmt24 && hour_bin == 5'd11 && min_tens == 3'h5
     && min_ones == 4'h9 && sec_tens == 3'h5 && sec_ones == 4'h9)
    |=> (hour_bin == 5'd0 && afternoon != $past(afternoon)))
    else $error("12-hour wrap wrong");
  a_soft_hold: assert property (@(posedge clk_sys) disable iff (!nrst) // R11
    (clk_en && soft_rst) |=> (hour_bin == 5'd0 && weekday == 3'h0 && !run))
    else $error("soft reset did not clear");
  a_busy_len: assert property (@(posedge clk_sys) disable iff (!nrst) // R01
    (clk_en && busy && busy_cnt == 4'h1 && !sec_tick) |=> !busy)
    else $error("busy held past its window");
  a_wk_range: assert property (@(posedge clk_sys) disable iff (!nrst) // R06
    (clk_en && !bus.wr && weekday <= `WEEKDAY_SATURDAY) |=> (weekday <= `WEEKDAY_SATURDAY))
    else $error("weekday counted into the invalid code");
  a_tens_range: assert property (@(posedge clk_sys) disable iff (!nrst) // R04
    (clk_en && !bus.wr && hr_tens <= 2'h2 && hr_ones <= 4'h9 && hour_bin <= 5'd23)
    |=> (hr_tens <= 2'h2))
    else $error("hour tens counted past two");
  a_pm_hold: assert property (@(posedge clk_sys) disable iff (!nrst) // R10
    (clk_en && fmt24 && !bus.wr && !soft_rst) |=> $stable(afternoon))
    else $error("afternoon flag moved in 24-hour mode");
  a_day_12h: assert property (@(posedge clk_sys) disable iff (!nrst) // R15
    (clk_en && hour_carry && !bus.wr && !fmt24 && !afternoon && hour_bin == 5'd11)
    |=> ($stable(weekday) && afternoon))
    else $error("noon wrap changed the weekday");
  a_soft_src: assert property (@(posedge clk_sys) disable iff (!nrst) // R11
    (clk_en && soft_rst && !bus.wr) |=> ($stable(src_sel) && soft_rst))
    else $error("soft reset disturbed source select");
  a_hour_ones: assert property (@(posedge clk_sys) disable iff (!nrst) // R05
    (clk_en && !bus.wr && hr_ones <= 4'h9) |=> (hr_ones <= 4'h9))
    else $error("hour ones digit counted past nine");
  a_min_carry: assert property (@(posedge clk_sys) disable iff (!nrst) // R14
    (clk_en && hour_carry && !bus.wr) |=> (min_ones == 4'h0 && min_tens == 3'h0))
    else $error("minutes did not wrap on the hourly carry");
endmodule

// ===== test/rtc_hour_weekday_tb.sv
// Self-checking bench for the hour/weekday calendar block.
// Assumes the block's package and constants header are compiled first.
`timescale 1ns/1ps
`include "rtc_hour_consts.svh"
module rtc_hour_weekday_tb;
  import rtc_hour_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic tick_32k = 1'b0;
  bus_req_t bus = '0;
  logic [7:0] rdata;
  int err_count = 0;
  int cmp_count = 0;
  logic [7:0] d;

  always #12.5 clk_sys = ~clk_sys;

  // Short second so a full hour carry takes only four ticks
  rtc_hour_weekday #(.TICKS_PER_SECOND(4)) dut (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clk_en(clk_en),
    .tick_32k(tick_32k),
    .bus(bus),
    .rdata(rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: read %h expected %h", $time, got, exp);
    end
  endtask

  // One idle cycle after each strobe keeps every driver edge distinct
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_sys) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys) bus <= '0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk_sys) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys) bus <= '0;
    #1 v = rdata;
  endtask

  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_sys) tick_32k <= 1'b1;
      @(posedge clk_sys) tick_32k <= 1'b0;
    end
  endtask

  // Sets hh:59:59, lets one second pass, polls through the busy window
  task automatic hour_step(input logic [7:0] hr, input logic [7:0] exp);
    logic seen;
    seen = 1'b0;
    wr(`OFS_SECOND_COUNT, 8'h59);
    wr(`OFS_MINUTE_COUNT, 8'h59);
    wr(`OFS_HOUR_COUNT, hr);
    pulse(4);
    for (int i = 0; i < 8; i++) begin
      rd(`OFS_HOUR_COUNT, d);
      if (d[7] === 1'b1) seen = 1'b1;
      else if (seen) break;
    end
    chk({7'h00, seen}, 8'h01);
    chk(d, exp);
    rd(`OFS_MINUTE_COUNT, d);
    chk(d, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_fields;
    rd(`OFS_HOUR_COUNT, d); chk(d, 8'h00);
    rd(`OFS_CLOCK_SOURCE_SELECT, d); chk(d, 8'h08);
    wr(`OFS_HOUR_COUNT, 8'hff);
    rd(`OFS_HOUR_COUNT, d); chk(d, 8'h3f);
    wr(`OFS_WEEKDAY_COUNT, 8'hff);
    rd(`OFS_WEEKDAY_COUNT, d); chk(d, 8'h07);
    wr(`OFS_CLOCK_CONTROL_ONE, 8'h0f);
    rd(`OFS_CLOCK_CONTROL_ONE, d); chk(d, 8'h00);
    wr(16'hf070, 8'hff);
    rd(16'hf070, d); chk(d, 8'h00);
  endtask

  task automatic t_count24;
    wr(`OFS_CLOCK_CONTROL_ONE, 8'hc0);
    wr(`OFS_WEEKDAY_COUNT, 8'h02);
    hour_step(8'h09, 8'h10);
    hour_step(8'h23, 8'h00);
    rd(`OFS_WEEKDAY_COUNT, d); chk(d, 8'h03);
    wr(`OFS_WEEKDAY_COUNT, {5'h00, `WEEKDAY_SATURDAY});
    hour_step(8'h23, 8'h00);
    rd(`OFS_WEEKDAY_COUNT, d); chk(d, 8'h00);
  endtask

  task automatic t_count12;
    wr(`OFS_CLOCK_CONTROL_ONE, 8'h80);
    wr(`OFS_WEEKDAY_COUNT, 8'h03);
    hour_step(8'h11, 8'h00);
    rd(`OFS_CLOCK_CONTROL_ONE, d); chk(d, 8'ha0);
    rd(`OFS_WEEKDAY_COUNT, d); chk(d, 8'h03);
    hour_step(8'h11, 8'h00);
    rd(`OFS_CLOCK_CONTROL_ONE, d); chk(d, 8'h80);
    rd(`OFS_WEEKDAY_COUNT, d); chk(d, 8'h04);
  endtask

  // A whole second leaked past a gate shows up in that step's hour read; a partial leak goes unseen
  task automatic t_halt;
    wr(`OFS_CLOCK_CONTROL_ONE, 8'h40);
    wr(`OFS_SECOND_COUNT, 8'h59);
    wr(`OFS_MINUTE_COUNT, 8'h59);
    wr(`OFS_HOUR_COUNT, 8'h05);
    pulse(4);
    rd(`OFS_HOUR_COUNT, d); chk(d, 8'h05);
    wr(`OFS_CLOCK_CONTROL_ONE, 8'hc0);
    @(posedge clk_sys) clk_en <= 1'b0;
    pulse(4);
    @(posedge clk_sys) clk_en <= 1'b1;
    rd(`OFS_HOUR_COUNT, d); chk(d, 8'h05);
    wr(`OFS_CLOCK_SOURCE_SELECT, 8'h00);
    pulse(4);
    rd(`OFS_HOUR_COUNT, d); chk(d, 8'h05);
    wr(`OFS_CLOCK_SOURCE_SELECT, 8'h08);
    pulse(4);
    repeat (6) @(posedge clk_sys);
    rd(`OFS_HOUR_COUNT, d); chk(d, 8'h06);
  endtask

  task automatic t_softrst;
    wr(`OFS_CLOCK_SOURCE_SELECT, 8'h09);
    wr(`OFS_CLOCK_CONTROL_ONE, 8'h90);
    rd(`OFS_HOUR_COUNT, d); chk(d, 8'h00);
    rd(`OFS_CLOCK_CONTROL_ONE, d); chk(d, 8'h10);
    rd(`OFS_CLOCK_SOURCE_SELECT, d); chk(d, 8'h09);
    wr(`OFS_HOUR_COUNT, 8'h05);
    rd(`OFS_HOUR_COUNT, d); chk(d, 8'h00);
    wr(`OFS_CLOCK_CONTROL_ONE, 8'h00);
    wr(`OFS_HOUR_COUNT, 8'h05);
    rd(`OFS_HOUR_COUNT, d); chk(d, 8'h05);
  endtask

  // Mid-run hardware reset restores the source select default
  task automatic t_hwreset;
    @(posedge clk_sys) nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(`OFS_CLOCK_SOURCE_SELECT, d); chk(d, 8'h08);
    rd(`OFS_HOUR_COUNT, d); chk(d, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    t_fields;
    t_count24;
    t_count12;
    t_halt;
    t_softrst;
    t_hwreset;
    end_of_test;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #125000;
    err_count++;
    end_of_test;
  end
endmodule
